// >>> rtl/psq_pkg.sv
package psq_pkg;
  // Datapath widths
  localparam int PC_W = 11;
  localparam int WORD_W = 14;
  localparam int STK_DEPTH = 4;
  localparam int PCL_W = 8;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL = 8'h01;
  localparam logic [7:0] IDX_STAT = 8'h02;
  localparam logic [7:0] IDX_PCL = 8'h06;
  localparam logic [7:0] ADDR_CTRL = IDX_CTRL << 2;
  localparam logic [7:0] ADDR_STAT = IDX_STAT << 2;
  localparam logic [7:0] ADDR_PCL = IDX_PCL << 2;
  // Control register fields
  localparam int CTRL_W = 4;
  localparam int CTRL_TB_EN = 0;
  localparam int CTRL_T0_EN = 1;
  localparam int CTRL_T1_EN = 2;
  localparam int CTRL_GIE = 3;
  localparam logic [3:0] CTRL_RST = 4'h0;
  // Status register fields
  localparam int STAT_LVL_LSB = 0;
  localparam int STAT_PEND_LSB = 3;
  localparam int STAT_RUN = 6;
  localparam int STAT_HALT = 7;
  // Fixed program addresses
  localparam logic [10:0] VEC_RESET = 11'h000;
  localparam logic [10:0] VEC_TB = 11'h004;
  localparam logic [10:0] VEC_T0 = 11'h008;
  localparam logic [10:0] VEC_T1 = 11'h00c;
  // Instruction cycle is four clocks, phase 3 closes it
  localparam logic [1:0] PHASE_LAST = 2'h3;
  // Start-up wait, counted in system clock periods
  localparam int SST_PERIODS = 1024;
  localparam int CLK_PER_SYS = 1;
  localparam int SST_CYC = SST_PERIODS * CLK_PER_SYS;
endpackage

// >>> rtl/psq_sequencer.sv
`timescale 1ns/100ps
// Summary of operation
// - Instruction cycle is four clock phases
// - Fetch next word while executing current one
// - Control transfers add one dummy cycle
// - Eleven-bit counter addresses program ROM
// - Counter increments after every fetch
// - True skip discards prefetch, goes PC+2
// - Low counter byte is a register
// - Low byte write jumps within page
// - Reset clears counter, fetch from zero
// - First timer interrupt vectors to 008
// - Second timer interrupt vectors to 00C
// - Jump and call load instruction address
// - Returns load counter from stack top
// - Wait 1024 clocks after power-up, wake
// - Time base interrupt vectors to 004
// - Four-level stack, push call, pop return
// - Full stack withholds interrupt acknowledge
// - Call on full stack drops oldest
module psq_sequencer #(
  parameter int STACK_DEPTH = psq_pkg::STK_DEPTH,
  parameter int SST_CYCLES = psq_pkg::SST_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Program ROM
  output logic [psq_pkg::PC_W-1:0] rom_addr,
  input wire logic [psq_pkg::WORD_W-1:0] rom_data,
  // Execute stage
  output logic [psq_pkg::WORD_W-1:0] exec_word,
  output logic exec_valid,
  output logic [1:0] exec_phase,
  input wire logic ctl_jump,
  input wire logic ctl_call,
  input wire logic ctl_ret,
  input wire logic ctl_interrupt_return,
  input wire logic ctl_skip,
  input wire logic halt_req,
  // Interrupt sources and wake pin
  input wire logic irq_tb,
  input wire logic irq_t0,
  input wire logic irq_t1,
  input wire logic wake_pin,
  // Status
  output logic [$clog2(STACK_DEPTH+1)-1:0] stack_level_pointer
);
  localparam int LW = $clog2(STACK_DEPTH + 1);
  localparam int CW = $clog2(SST_CYCLES + 1);
  localparam int PW = psq_pkg::PC_W;

  typedef enum logic [1:0] {ST_START, ST_RUN, ST_HALT} psq_state_t;

  typedef struct packed {
    psq_state_t st;
    logic [1:0] phase;
    logic [PW-1:0] pc;
    logic [psq_pkg::WORD_W-1:0] ir;
    logic ir_ok;
    logic [STACK_DEPTH-1:0][PW-1:0] stk;
    logic [LW-1:0] lvl;
    logic [2:0] pend;
    logic [psq_pkg::CTRL_W-1:0] ctrl;
    logic pcl_pend;
    logic [psq_pkg::PCL_W-1:0] pcl_val;
    logic [CW-1:0] sst_cnt;
    logic [2:0] wk;
    logic wk_lvl;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } psq_regs_t;

  psq_regs_t r;
  psq_regs_t n;
  logic cyc_end;
  logic wake_rise;
  logic xfer;
  logic ack;
  logic full;
  logic apb_wr;
  logic [2:0] pend_en;
  logic [PW-1:0] tgt;

  always_comb begin
    n = r;
    xfer = 1'b0;
    ack = 1'b0;
    tgt = r.pc;
    cyc_end = (r.st == ST_RUN) && (r.phase == psq_pkg::PHASE_LAST);
    full = (r.lvl == LW'(STACK_DEPTH));
    pend_en = r.pend & r.ctrl[psq_pkg::CTRL_T1_EN:psq_pkg::CTRL_TB_EN];
    // Only stages two and three decide the wake level
    n.wk = {r.wk[1:0], wake_pin};
    if (r.wk[1] == r.wk[2]) begin
      n.wk_lvl = r.wk[2];
    end
    wake_rise = (r.wk[1] == r.wk[2]) && r.wk[2] && !r.wk_lvl;
    case (r.st)
      ST_START: begin
        n.phase = 2'h0;
        n.ir_ok = 1'b0;
        n.sst_cnt = r.sst_cnt + CW'(1);
        if (r.sst_cnt == CW'(SST_CYCLES - 1)) begin
          n.st = ST_RUN;
          n.sst_cnt = '0;
        end
      end
      ST_RUN: begin
        n.phase = r.phase + 2'h1;
        if (cyc_end) begin
          if (r.ir_ok && halt_req) begin
            // Keep pc so the discarded prefetch is fetched again
            n.st = ST_HALT;
            n.ir_ok = 1'b0;
          end else if (r.ir_ok && (ctl_ret || ctl_interrupt_return)) begin
            xfer = 1'b1;
            tgt = r.stk[0];
            for (int i = 0; i < STACK_DEPTH - 1; i++) begin
              n.stk[i] = r.stk[i+1];
            end
            if (r.lvl != '0) begin
              n.lvl = r.lvl - LW'(1);
            end
            if (ctl_interrupt_return) begin
              n.ctrl[psq_pkg::CTRL_GIE] = 1'b1;
            end
          end else if (r.ir_ok && (ctl_jump || ctl_call)) begin
            xfer = 1'b1;
            tgt = r.ir[PW-1:0];
            if (ctl_call) begin
              n.stk[0] = r.pc;
              for (int i = 1; i < STACK_DEPTH; i++) begin
                n.stk[i] = r.stk[i-1];
              end
              if (!full) begin
                n.lvl = r.lvl + LW'(1);
              end
            end
          end else if (r.ir_ok && ctl_skip) begin
            xfer = 1'b1;
            tgt = r.pc + PW'(1);
          end else if (r.pcl_pend) begin
            xfer = 1'b1;
            tgt = {r.pc[PW-1:psq_pkg::PCL_W], r.pcl_val};
            n.pcl_pend = 1'b0;
          end else if (r.ir_ok && r.ctrl[psq_pkg::CTRL_GIE] &&
                       (pend_en != 3'h0) && !full) begin
            xfer = 1'b1;
            ack = 1'b1;
            n.ctrl[psq_pkg::CTRL_GIE] = 1'b0;
            // Prefetched word is the next one not yet executed
            n.stk[0] = r.pc;
            for (int i = 1; i < STACK_DEPTH; i++) begin
              n.stk[i] = r.stk[i-1];
            end
            n.lvl = r.lvl + LW'(1);
            if (pend_en[0]) begin
              tgt = psq_pkg::VEC_TB;
              n.pend[0] = 1'b0;
            end else if (pend_en[1]) begin
              tgt = psq_pkg::VEC_T0;
              n.pend[1] = 1'b0;
            end else begin
              tgt = psq_pkg::VEC_T1;
              n.pend[2] = 1'b0;
            end
          end
          if (xfer) begin
            n.pc = tgt;
            n.ir_ok = 1'b0;
          end else if (!(r.ir_ok && halt_req)) begin
            n.pc = r.pc + PW'(1);
            n.ir = rom_data;
            n.ir_ok = 1'b1;
          end
        end
      end
      ST_HALT: begin
        n.phase = 2'h0;
        if (wake_rise) begin
          n.st = ST_START;
        end
      end
      default: begin
        n.st = ST_START;
      end
    endcase
    // Zero-wait APB: answer is prepared in the setup cycle
    n.pready = psel && !penable;
    n.pslverr = 1'b0;
    if (psel && !penable) begin
      n.prdata = '0;
      case (paddr)
        psq_pkg::ADDR_CTRL: n.prdata[psq_pkg::CTRL_W-1:0] = r.ctrl;
        psq_pkg::ADDR_STAT: begin
          n.prdata[psq_pkg::STAT_LVL_LSB +: LW] = r.lvl;
          n.prdata[psq_pkg::STAT_PEND_LSB +: 3] = r.pend;
          n.prdata[psq_pkg::STAT_RUN] = (r.st == ST_RUN);
          n.prdata[psq_pkg::STAT_HALT] = (r.st == ST_HALT);
        end
        psq_pkg::ADDR_PCL: n.prdata[7:0] = r.pc[7:0];
        default: n.pslverr = 1'b1;
      endcase
    end
    apb_wr = psel && penable && r.pready && pwrite;
    if (apb_wr && paddr == psq_pkg::ADDR_CTRL) begin
      n.ctrl = pwdata[psq_pkg::CTRL_W-1:0];
    end
    // A write in the consuming cycle still lands
    if (apb_wr && paddr == psq_pkg::ADDR_PCL) begin
      n.pcl_pend = 1'b1;
      n.pcl_val = pwdata[7:0];
    end
    // Requests raised during acknowledge are kept
    n.pend = n.pend | {irq_t1, irq_t0, irq_tb};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.ctrl <= psq_pkg::CTRL_RST;
      r.pc <= psq_pkg::VEC_RESET;
    end else begin
      r <= n;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign rom_addr = r.pc;
  assign exec_word = r.ir;
  assign exec_valid = r.ir_ok;
  assign exec_phase = r.phase;
  assign stack_level_pointer = r.lvl;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence run_cycle_s;
    r.phase == 2'h1 ##1 r.phase == 2'h2 ##1 r.phase == 2'h3;
  endsequence

  sequence dummy_s;
    !exec_valid [*4];
  endsequence

  wire plain_end = cyc_end && !halt_req && !ctl_ret && !ctl_interrupt_return;
  wire do_jump = plain_end && r.ir_ok && (ctl_jump || ctl_call);
  wire do_skip = plain_end && r.ir_ok && ctl_skip && !ctl_jump &&
                 !ctl_call;

  phase_cycle_a: assert property (
    (r.st == ST_RUN && r.phase == 2'h0) |=> run_cycle_s)
    else $error("phase sequence broken");

  fetch_step_a: assert property (
    (plain_end && !do_jump && !do_skip && !r.pcl_pend && !ack)
    |=> r.pc == $past(r.pc) + PW'(1) && r.ir == $past(rom_data))
    else $error("fetch did not advance pc");

  overlap_a: assert property (
    (cyc_end && !xfer && !(r.ir_ok && halt_req)) |=> exec_valid [*4])
    else $error("pipeline lost a cycle");

  dummy_cycle_a: assert property (
    (cyc_end && xfer) |=> dummy_s)
    else $error("no dummy cycle after transfer");

  ret_load_a: assert property (
    (cyc_end && !halt_req && r.ir_ok && ctl_ret)
    |=> r.pc == $past(r.stk[0]))
    else $error("return address not loaded");

  jump_load_a: assert property (
    do_jump |=> r.pc == $past(r.ir[PW-1:0]))
    else $error("jump target not loaded");

  skip_step_a: assert property (
    do_skip |=> r.pc == $past(r.pc) + PW'(1) && !r.ir_ok)
    else $error("skip did not reach pc plus two");

  pcl_jump_a: assert property (
    (cyc_end && r.pcl_pend && !(r.ir_ok && (halt_req || ctl_ret ||
     ctl_interrupt_return || ctl_jump || ctl_call || ctl_skip)))
    |=> r.pc == {$past(r.pc[PW-1:8]), $past(r.pcl_val)})
    else $error("short jump left the page");

  full_hold_a: assert property (
    (cyc_end && full && !(r.ir_ok && (ctl_ret || ctl_interrupt_return)))
    |=> ($past(r.pend) & ~r.pend) == 3'h0)
    else $error("interrupt taken on full stack");

  vector_push_a: assert property (
    ack |=> r.stk[0] == $past(r.pc) &&
    (r.pc == psq_pkg::VEC_TB || r.pc == psq_pkg::VEC_T0 ||
     r.pc == psq_pkg::VEC_T1))
    else $error("interrupt vectoring wrong");

  start_wait_a: assert property (
    (r.st == ST_RUN && $past(r.st) == ST_START)
    |-> $past(r.sst_cnt) == CW'(SST_CYCLES - 1))
    else $error("start-up wait too short");

  flush_a: assert property (
    r.st == ST_START |-> !exec_valid)
    else $error("stale instruction during start-up");

  tb_vector_a: assert property (
    (ack && pend_en[0]) |=> r.pc == psq_pkg::VEC_TB)
    else $error("time base vector wrong");

  t0_vector_a: assert property (
    (ack && pend_en[1:0] == 2'h2) |=> r.pc == psq_pkg::VEC_T0)
    else $error("first timer vector wrong");

  t1_vector_a: assert property (
    (ack && pend_en == 3'h4) |=> r.pc == psq_pkg::VEC_T1)
    else $error("second timer vector wrong");

  full_call_a: assert property (
    (cyc_end && full && r.ir_ok && ctl_call && !halt_req && !ctl_ret &&
     !ctl_interrupt_return) |=> r.lvl == LW'(STACK_DEPTH) && r.stk[0] == $past(r.pc)
    && r.stk[STACK_DEPTH-1] == $past(r.stk[STACK_DEPTH-2]))
    else $error("call on full stack mishandled");

  halt_hold_a: assert property (
    (cyc_end && r.ir_ok && halt_req)
    |=> r.st == ST_HALT && r.pc == $past(r.pc) && !exec_valid)
    else $error("halt did not hold the counter");
endmodule // psq_sequencer

// >>> testbench/program_sequencer_test.sv
`timescale 1ns/100ps
module program_sequencer_test;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [31:0] pwdata = 32'h0;
  logic ctl_jump = 1'h0;
  logic ctl_call = 1'h0;
  logic ctl_ret = 1'h0;
  logic ctl_interrupt_return = 1'h0;
  logic ctl_skip = 1'h0;
  logic irq_tb = 1'h0;
  logic irq_t0 = 1'h0;
  logic irq_t1 = 1'h0;
  logic halt_req = 1'h0;
  logic wake_pin = 1'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [10:0] rom_addr;
  logic [13:0] rom_data;
  logic [13:0] exec_word;
  logic exec_valid;
  logic [1:0] exec_phase;
  logic [1:0] last_ph = 2'h0;
  logic [2:0] lvl;
  logic [14:0] expq[$];
  logic [10:0] stk[$];
  logic [10:0] ex = 11'h0;
  logic [2:0] pend = 3'h0;
  logic gie = 1'h1;
  logic [7:0] pcl_d;
  int errors = 0;
  int checks_done = 0;
  int cyc = 0;
  psq_sequencer #(.SST_CYCLES(16)) psq_sequencer_i (.pclk(pclk),
    .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rom_addr(rom_addr), .rom_data(rom_data),
    .exec_word(exec_word), .exec_valid(exec_valid),
    .exec_phase(exec_phase), .ctl_jump(ctl_jump), .ctl_call(ctl_call),
    .ctl_ret(ctl_ret), .ctl_interrupt_return(ctl_interrupt_return), .ctl_skip(ctl_skip),
    .halt_req(halt_req), .irq_tb(irq_tb), .irq_t0(irq_t0),
    .irq_t1(irq_t1), .wake_pin(wake_pin), .stack_level_pointer(lvl));
  psq_rom_model psq_rom_model_i (.rom_addr(rom_addr), .rom_data(rom_data));
  always #20 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  function automatic logic [10:0] tgt(logic [10:0] a);
    return a ^ 11'h2aa;
  endfunction
  task automatic end_of_test();
    $display("errors %0d checks_done %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic fail(string s);
    errors++;
    $display("BAD %s expected done seen hang", s);
    end_of_test();
  endtask
  task automatic chk(string s, logic [31:0] x, logic [31:0] g);
    checks_done++;
    if (g !== x) begin
      errors++;
      $display("BAD %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) fail("pready");
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // Acts on the next valid cycle; k picks the decode outcome
  task automatic do_ins(int k, logic [2:0] irq);
    int n;
    logic [10:0] nx;
    logic tr;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (!(exec_valid === 1'h1 && exec_phase === 2'h1) && n < 40);
    if (n >= 40) fail("cycle");
    {irq_t1, irq_t0, irq_tb} <= irq;
    @(posedge pclk);
    {irq_t1, irq_t0, irq_tb} <= 3'h0;
    {ctl_skip, ctl_interrupt_return, ctl_ret, ctl_call, ctl_jump} <=
      (k > 0 && k < 6) ? 5'h1 << (k - 1) : 5'h0;
    halt_req <= (k == 7);
    @(posedge pclk);
    {ctl_skip, ctl_interrupt_return, ctl_ret, ctl_call, ctl_jump} <= 5'h0;
    halt_req <= 1'h0;
    pend = pend | irq;
    tr = 1'h1;
    nx = ex + 11'h1;
    case (k)
      1: nx = tgt(ex);
      2: begin
        stk.push_back(nx);
        // Overflow drops the oldest return address
        if (stk.size() > psq_pkg::STK_DEPTH) void'(stk.pop_front());
        nx = tgt(ex);
      end
      3, 4: begin
        nx = stk.pop_back();
        if (k == 4) gie = 1'h1;
      end
      5: nx = ex + 11'h2;
      6: nx = {nx[10:8], pcl_d};
      // Halt drops the prefetch; the same word runs after wake
      7: nx = ex + 11'h1;
      default: if (gie && pend != 3'h0 &&
                   stk.size() < psq_pkg::STK_DEPTH) begin
        stk.push_back(nx);
        gie = 1'h0;
        if (pend[0]) nx = psq_pkg::VEC_TB;
        else if (pend[1]) nx = psq_pkg::VEC_T0;
        else nx = psq_pkg::VEC_T1;
        pend = pend & (pend - 3'h1);
      end else tr = 1'h0;
    endcase
    if (tr) expq.push_back({3'(stk.size()), 1'h0, 11'h0});
    expq.push_back({3'(stk.size()), 1'h1, nx});
    ex = nx;
  endtask
  always @(negedge pclk) begin
    logic [14:0] e;
    if (exec_phase === 2'h0 && last_ph === 2'h3) begin
      if (expq.size() == 0) fail("queue");
      e = expq.pop_front();
      chk("exec_valid", 32'(e[11]), 32'(exec_valid));
      if (e[11])
        chk("exec_word", {18'h0, 3'h5, tgt(e[10:0])}, 32'(exec_word));
      chk("level", 32'(e[14:12]), 32'(lvl));
    end
    last_ph = exec_phase;
  end
  initial begin
    #2400000;
    fail("run");
  end
  initial begin
    logic [31:0] r;
    logic [31:0] x;
    logic e;
    int rel;
    int n;
    void'($urandom(32'h5d45));
    expq.push_back({3'h0, 1'h1, 11'h0});
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    rel = cyc;
    apb(1'h0, psq_pkg::ADDR_CTRL, 32'h0, r, e);
    chk("ctrl", 32'(psq_pkg::CTRL_RST), r);
    apb(1'h1, psq_pkg::ADDR_CTRL, 32'hf, r, e);
    apb(1'h0, psq_pkg::ADDR_CTRL, 32'h0, r, e);
    chk("ctrl", 32'hf, r);
    apb(1'h0, 8'h40, 32'h0, r, e);
    chk("pslverr", 32'h1, 32'(e));
    apb(1'h0, psq_pkg::ADDR_PCL, 32'h0, r, e);
    chk("pcl", 32'h0, r);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (exec_valid !== 1'h1 && n < 100);
    chk("startup", 32'h1, 32'((cyc - rel) > 16));
    do_ins(0, 3'h0);
    do_ins(5, 3'h0);
    do_ins(1, 3'h0);
    do_ins(2, 3'h0);
    do_ins(0, 3'h0);
    do_ins(3, 3'h0);
    do_ins(0, 3'h0);
    pcl_d = 8'($urandom);
    fork
      apb(1'h1, psq_pkg::ADDR_PCL, {24'h0, pcl_d}, r, e);
      do_ins(6, 3'h0);
    join
    do_ins(0, 3'h7);
    repeat (3) begin
      do_ins(4, 3'h0);
      do_ins(0, 3'h0);
    end
    repeat (4) do_ins(2, 3'h0);
    do_ins(0, 3'h1);
    do_ins(2, 3'h0);
    do_ins(3, 3'h0);
    do_ins(0, 3'h0);
    do_ins(4, 3'h0);
    repeat (3) do_ins(3, 3'h0);
    do_ins(7, 3'h0);
    apb(1'h0, psq_pkg::ADDR_STAT, 32'h0, r, e);
    x = 32'h1 << psq_pkg::STAT_HALT;
    x = x | (32'(pend) << psq_pkg::STAT_PEND_LSB);
    x = x | (32'(stk.size()) << psq_pkg::STAT_LVL_LSB);
    chk("stat", x, r);
    wake_pin <= 1'h1;
    do_ins(0, 3'h0);
    end_of_test();
  end
endmodule // program_sequencer_test

// >>> testbench/psq_rom_model.sv
`timescale 1ns/100ps
module psq_rom_model (
  // Fetch port
  input wire logic [10:0] rom_addr,
  output logic [13:0] rom_data
);
  // Word content tied to its address so a wrong fetch shows
  assign rom_data = {3'h5, rom_addr ^ 11'h2aa};
endmodule // psq_rom_model
